// [verilog/timer_consts.vh]
// Constants for the dual eight-bit event timer
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

`define ADDR_CLOCK_SELECT 4'h0
`define ADDR_MODE_CONTROL 4'h1
`define ADDR_OUTPUT_CONTROL 4'h2
`define ADDR_COMPARE_ONE 4'h3
`define ADDR_COMPARE_TWO 4'h4
`define ADDR_COUNTER_ONE 4'h5
`define ADDR_COUNTER_TWO 4'h6

`define MODE_ENABLE_ONE_BIT 0
`define MODE_ENABLE_TWO_BIT 1
`define MODE_CASCADE_BIT 2
`define MODE_MASK 8'h07

`define OUT_WAVE_ONE_BIT 0
`define OUT_SET_ONE_BIT 2
`define OUT_RESET_ONE_BIT 3
`define OUT_WAVE_TWO_BIT 4
`define OUT_SET_TWO_BIT 6
`define OUT_RESET_TWO_BIT 7
`define OUT_READ_MASK 8'h11

`define CTRL_RESET 8'h00
`define COUNT_RESET 8'h00
`define COUNT_MAX 8'hff

`define CODE_FALL 4'h0
`define CODE_RISE 4'h1
`define CODE_DIV4 4'h6
`define CODE_DIV8 4'h7
`define CODE_DIV16 4'h8
`define CODE_DIV32 4'h9
`define CODE_DIV64 4'ha
`define CODE_DIV128 4'hb
`define CODE_DIV256 4'hc
`define CODE_DIV512 4'hd
`define CODE_DIV1024 4'he
`define CODE_DIV4096 4'hf

`define PRESCALE_WIDTH 12
`define PRESCALE_RESET 12'h000

`endif

// [verilog/dual_event_timer.v]
// Two 8-bit event timers with compare, square wave and cascade mode
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"

module dual_event_timer (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire event_pin_one,
  input wire event_pin_two,
  output reg wave_out_one,
  output reg wave_out_two,
  output reg match_irq_one,
  output reg match_irq_two
);

  reg [7:0] clock_select_r;
  reg [7:0] mode_control_r;
  reg [7:0] output_control_r;
  reg [7:0] compare_one_r;
  reg [7:0] compare_two_r;
  reg [7:0] counter_one_r;
  reg [7:0] counter_two_r;
  reg [7:0] counter_one_nxt;
  reg [7:0] counter_two_nxt;
  reg level_one_r;
  reg level_two_r;
  reg level_one_nxt;
  reg level_two_nxt;
  reg [`PRESCALE_WIDTH-1:0] prescale_r;
  reg hit_one;
  reg hit_two;

  wire [3:0] low_clock_select_field;
  wire [3:0] high_clock_select_field;
  wire cascade_select_bit;
  wire count_enable_bit;
  wire enable_two;
  wire wave_enable_one;
  wire wave_enable_two;
  wire rise_one;
  wire fall_one;
  wire rise_two;
  wire fall_two;
  wire tick_one;
  wire tick_two;
  wire pulse_one;
  wire pulse_two;
  wire match_one;
  wire match_two;
  wire overflow_one;
  wire full_match;
  wire wr_out;

  wire [1:0] pin_in;
  wire [1:0] pin_rise;
  wire [1:0] pin_fall;
  wire [`PRESCALE_WIDTH-1:0] pre_tap;

  assign low_clock_select_field = clock_select_r[3:0];
  assign high_clock_select_field = clock_select_r[7:4];
  assign cascade_select_bit = mode_control_r[`MODE_CASCADE_BIT];
  assign count_enable_bit = mode_control_r[`MODE_ENABLE_ONE_BIT];
  assign enable_two = mode_control_r[`MODE_ENABLE_TWO_BIT];
  assign wave_enable_one = output_control_r[`OUT_WAVE_ONE_BIT];
  assign wave_enable_two = output_control_r[`OUT_WAVE_TWO_BIT];
  assign wr_out = reg_wr && (reg_addr == `ADDR_OUTPUT_CONTROL);

  // Pins are asynchronous: two stages settle them, the third holds
  // the previous level so an edge is seen exactly once
  assign pin_in = {event_pin_two, event_pin_one};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_pin
      reg [2:0] sync_r;
      wire settled;
      wire previous;
      always @(posedge ref_clk)
      begin
        if (rst)
          sync_r <= 3'h0;
        else if (clk_en)
          sync_r <= {sync_r[1:0], pin_in[ch]};
      end
      // Edge detect reads only the settled second and third stages
      assign settled = sync_r[1];
      assign previous = sync_r[2];
      assign pin_rise[ch] = settled && !previous;
      assign pin_fall[ch] = !settled && previous;
    end
  endgenerate

  assign rise_one = pin_rise[0];
  assign fall_one = pin_fall[0];
  assign rise_two = pin_rise[1];
  assign fall_two = pin_fall[1];

  // One tap per prescaler bit: high while that bit and all below are
  // ones, so a divide by two to the n ticks on tap n minus one
  genvar tb;
  generate
    for (tb = 0; tb < `PRESCALE_WIDTH; tb = tb + 1)
    begin : g_tap
      assign pre_tap[tb] = &prescale_r[tb:0];
    end
  endgenerate

  // Count clock select; undefined codes give no count pulse
  function count_tick;
    input [3:0] code;
    input [`PRESCALE_WIDTH-1:0] pre;
    input rise;
    input fall;
    begin
      case (code)
        `CODE_FALL: count_tick = fall;
        `CODE_RISE: count_tick = rise;
        `CODE_DIV4: count_tick = pre[1];
        `CODE_DIV8: count_tick = pre[2];
        `CODE_DIV16: count_tick = pre[3];
        `CODE_DIV32: count_tick = pre[4];
        `CODE_DIV64: count_tick = pre[5];
        `CODE_DIV128: count_tick = pre[6];
        `CODE_DIV256: count_tick = pre[7];
        `CODE_DIV512: count_tick = pre[8];
        `CODE_DIV1024: count_tick = pre[9];
        `CODE_DIV4096: count_tick = pre[11];
        default: count_tick = 1'b0;
      endcase
    end
  endfunction

  // Cascade uses channel one's clock source only, through the low nibble
  assign tick_one = count_tick(low_clock_select_field, pre_tap,
                               rise_one, fall_one);
  assign tick_two = count_tick(high_clock_select_field, pre_tap,
                               rise_two, fall_two);

  // Free-running prescaler: start is not aligned to it
  assign pulse_one = count_enable_bit && tick_one;
  // Equality only, so a compare lowered below the count waits for wrap
  assign match_one = pulse_one && (counter_one_r == compare_one_r);
  assign overflow_one = pulse_one && (counter_one_r == `COUNT_MAX);
  assign full_match = match_one && (counter_two_r == compare_two_r);
  // In cascade the second counter is clocked by overflow
  assign pulse_two = cascade_select_bit ? overflow_one
                   : (enable_two && tick_two);
  assign match_two = cascade_select_bit ? full_match
                   : (pulse_two && (counter_two_r == compare_two_r));

  always @*
  begin
    counter_one_nxt = counter_one_r;
    counter_two_nxt = counter_two_r;
    hit_one = match_one;
    hit_two = match_two;
    if (cascade_select_bit)
    begin
      // Only the enable bit starts or stops the pair
      // Channel two's enable and clock nibble are ignored here
      if (!count_enable_bit)
      begin
        counter_one_nxt = `COUNT_RESET;
        counter_two_nxt = `COUNT_RESET;
      end
      else if (full_match)
      begin
        counter_one_nxt = `COUNT_RESET;
        counter_two_nxt = `COUNT_RESET;
      end
      else if (pulse_one)
      begin
        counter_one_nxt = counter_one_r + 8'h01;
        if (pulse_two)
          counter_two_nxt = counter_two_r + 8'h01;
      end
    end
    else
    begin
      // Enable low holds zero, so a restart runs a full interval
      if (!count_enable_bit)
        counter_one_nxt = `COUNT_RESET;
      else if (match_one)
        counter_one_nxt = `COUNT_RESET;
      else if (pulse_one)
        counter_one_nxt = counter_one_r + 8'h01;
      if (!enable_two)
        counter_two_nxt = `COUNT_RESET;
      else if (match_two)
        counter_two_nxt = `COUNT_RESET;
      else if (pulse_two)
        counter_two_nxt = counter_two_r + 8'h01;
    end
  end

  // Output flip-flops; a software preset beats a same-cycle toggle
  always @*
  begin
    level_one_nxt = level_one_r;
    level_two_nxt = level_two_r;
    if (hit_one && wave_enable_one)
      level_one_nxt = !level_one_r;
    if (hit_two && wave_enable_two)
      level_two_nxt = !level_two_r;
    // Set wins over reset when both come in one write
    if (wr_out)
    begin
      if (reg_wdata[`OUT_SET_ONE_BIT])
        level_one_nxt = 1'b1;
      else if (reg_wdata[`OUT_RESET_ONE_BIT])
        level_one_nxt = 1'b0;
      if (reg_wdata[`OUT_SET_TWO_BIT])
        level_two_nxt = 1'b1;
      else if (reg_wdata[`OUT_RESET_TWO_BIT])
        level_two_nxt = 1'b0;
    end
  end

  // Control and timing state
  // Reset ignores clock enable so a frozen block can still be cleared
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      clock_select_r <= `CTRL_RESET;
      mode_control_r <= `CTRL_RESET;
      output_control_r <= `CTRL_RESET;
      counter_one_r <= `COUNT_RESET;
      counter_two_r <= `COUNT_RESET;
      level_one_r <= 1'b0;
      level_two_r <= 1'b0;
      prescale_r <= `PRESCALE_RESET;
      wave_out_one <= 1'b0;
      wave_out_two <= 1'b0;
      match_irq_one <= 1'b0;
      match_irq_two <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      prescale_r <= prescale_r + 12'h001;
      counter_one_r <= counter_one_nxt;
      counter_two_r <= counter_two_nxt;
      level_one_r <= level_one_nxt;
      level_two_r <= level_two_nxt;
      match_irq_one <= hit_one;
      match_irq_two <= hit_two;
      // Pin shows the level only while enabled; the ff keeps its state
      wave_out_one <= level_one_nxt && wave_enable_one;
      wave_out_two <= level_two_nxt && wave_enable_two;
      if (reg_wr)
      begin
        case (reg_addr)
          `ADDR_CLOCK_SELECT: clock_select_r <= reg_wdata;
          `ADDR_MODE_CONTROL: mode_control_r <= reg_wdata & `MODE_MASK;
          // Level bits are strobes and are not stored
          `ADDR_OUTPUT_CONTROL:
            output_control_r <= reg_wdata & `OUT_READ_MASK;
          default: ;
        endcase
      end
      // Read data stand one cycle, then fall back to zero
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `ADDR_CLOCK_SELECT: reg_rdata <= clock_select_r;
          `ADDR_MODE_CONTROL: reg_rdata <= mode_control_r;
          `ADDR_OUTPUT_CONTROL: reg_rdata <= output_control_r;
          `ADDR_COMPARE_ONE: reg_rdata <= compare_one_r;
          `ADDR_COMPARE_TWO: reg_rdata <= compare_two_r;
          `ADDR_COUNTER_ONE: reg_rdata <= counter_one_r;
          `ADDR_COUNTER_TWO: reg_rdata <= counter_two_r;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Compares have no reset value; software must load them first
  // A write lands at once, even while the counter runs
  always @(posedge ref_clk)
  begin
    if (clk_en && reg_wr)
    begin
      // Cascade writes while running are the caller's hazard
      if (reg_addr == `ADDR_COMPARE_ONE)
        compare_one_r <= reg_wdata;
      if (reg_addr == `ADDR_COMPARE_TWO)
        compare_two_r <= reg_wdata;
    end
  end

endmodule // dual_event_timer
`default_nettype wire

// [test/timer_props.sv]
// Port assertions for the dual event timer
`timescale 1ns/1ps
`default_nettype none
module timer_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic wave_out_one,
  input wire logic wave_out_two,
  input wire logic match_irq_one,
  input wire logic match_irq_two
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic ow1_r;
  logic ow2_r;
  // A preset reaches the pin one or two edges after its write
  always @(posedge ref_clk)
  begin
    ow1_r <= reg_wr && reg_addr == 4'h2;
    ow2_r <= ow1_r;
  end
  sequence s_ctrl_rd;
    reg_rd && reg_addr == 4'h2;
  endsequence
  sequence s_quiet;
    !match_irq_one && !match_irq_two && !wave_out_one && !wave_out_two;
  endsequence
  a_irq_one_pulse: assert property (
    match_irq_one |=> !match_irq_one) else $error("irq one too long");
  a_irq_two_pulse: assert property (
    match_irq_two |=> !match_irq_two) else $error("irq two too long");
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
  a_level_bits_zero: assert property (
    s_ctrl_rd |=> reg_rdata[3:2] == 2'b00 && reg_rdata[7:6] == 2'b00)
    else $error("level bits read back");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr > 4'h6 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_wave_one_cause: assert property (
    $changed(wave_out_one) |-> match_irq_one || ow1_r || ow2_r)
    else $error("wave one moved without cause");
  a_wave_two_cause: assert property (
    $changed(wave_out_two) |-> match_irq_two || ow1_r || ow2_r)
    else $error("wave two moved without cause");
  a_reset_quiet: assert property (
    $fell(rst) |-> s_quiet ##0 reg_rdata == 8'h00)
    else $error("outputs busy after reset");
endmodule // timer_props
`default_nettype wire

// [test/event_source.sv]
// Event pin source standing in for external pulse sources
`timescale 1ns/1ps
`default_nettype none
module event_source (
  input wire logic ref_clk,
  input wire logic [1:0] fire,
  output logic event_pin_one,
  output logic event_pin_two
);
  logic [3:0] c1 = 4'h0;
  logic [3:0] c2 = 4'h0;
  // Four cycles high, at least five low: slow enough for the synchroniser
  always @(posedge ref_clk)
  begin
    c1 <= (c1 != 4'h0) ? c1 - 4'h1 : {fire[0], 3'h0};
    c2 <= (c2 != 4'h0) ? c2 - 4'h1 : {fire[1], 3'h0};
  end
  assign event_pin_one = c1 > 4'h4;
  assign event_pin_two = c2 > 4'h4;
endmodule // event_source
`default_nettype wire

// [test/dual_event_timer_bench.sv]
// Bench for the dual event timer: registers, events, prescaler, cascade
`timescale 1ns/1ps
`default_nettype none
module dual_event_timer_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] fire = 2'b00;
  logic w;
  wire [7:0] reg_rdata;
  wire pin1, pin2, wave1, wave2, irq1, irq2;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int n1 = 0, l1 = 0, p1 = 0, l2 = 0, p2 = 0, d = 0;
  always #4 ref_clk = ~ref_clk;
  dual_event_timer dut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_pin_one(pin1),
    .event_pin_two(pin2), .wave_out_one(wave1), .wave_out_two(wave2),
    .match_irq_one(irq1), .match_irq_two(irq2));
  event_source src (.ref_clk(ref_clk), .fire(fire),
    .event_pin_one(pin1), .event_pin_two(pin2));
  task automatic print_verdict;
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
  endtask
  // Read data live only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pulse(input int i, input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n)
    begin
      fire[i] <= 1'b1;
      @(posedge ref_clk);
      fire[i] <= 1'b0;
      idle(10);
    end
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (irq1 === 1'b1)
    begin
      n1++;
      p1 = l1;
      l1 = cyc;
    end
    if (irq2 === 1'b1)
    begin
      p2 = l2;
      l2 = cyc;
    end
    if (cyc > 60000)
    begin
      n_fail++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    idle(1);
    for (int a = 0; a < 16; a++)
      if (a != 3 && a != 4)
        rd(4'(a), 8'h00);
    wr(4'h2, 8'h0d);
    rd(4'h2, 8'h01);
    idle(3);
    check(16'(wave1), 16'h0001);
    wr(4'h3, 8'h02);
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h01);
    pulse(0, 3);
    check(16'(n1), 16'h0001);
    check(16'(wave1), 16'h0000);
    rd(4'h5, 8'h00);
    pulse(1, 2);
    pulse(0, 1);
    rd(4'h5, 8'h01);
    wr(4'h0, 8'h00);
    pulse(0, 2);
    check(16'(n1), 16'h0002);
    check(16'(wave1), 16'h0001);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h10);
    wr(4'h1, 8'h02);
    d = l2;
    pulse(1, 1);
    check(16'(l2 != d), 16'h0001);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h02);
    d = n1;
    idle(40);
    check(16'(n1 - d), 16'h0000);
    for (int c = 6; c < 16; c++)
    begin
      wr(4'h0, 8'(c));
      d = (c == 15) ? 4096 : 4 << (c - 6);
      idle(3 * d);
      check(16'(l1 - p1), 16'(d));
    end
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h40);
    wr(4'h0, 8'h06);
    wr(4'h1, 8'h01);
    idle(128);
    wr(4'h3, 8'h08);
    d = n1;
    idle(400);
    check(16'(n1 - d), 16'h0000);
    idle(560);
    check(16'(n1 != d), 16'h0001);
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h01);
    wr(4'h4, 8'h01);
    wr(4'h2, 8'h10);
    wr(4'h0, 8'h06);
    wr(4'h1, 8'h05);
    idle(2100);
    #1;
    w = wave2;
    d = n1;
    idle(1032);
    #1;
    check(16'(l2 - p2), 16'h0408);
    check(16'(n1 - d), 16'h0002);
    check(16'(wave2), 16'(!w));
    print_verdict;
  end
endmodule // dual_event_timer_bench
bind dual_event_timer timer_props chk (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wave_out_one(wave_out_one),
  .wave_out_two(wave_out_two), .match_irq_one(match_irq_one),
  .match_irq_two(match_irq_two));
`default_nettype wire
